// ==== hub_pkg.sv ====
// Shared constants and types for the hub slot arbiter and its main memory.
// Assumes eight cores that hold a request steady until it is answered.
package hub_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CORES = 8;
  localparam int CORE_W = 3;
  localparam int MEM_ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int SLOT_PERIOD_CLKS = 16;
  localparam int HUB_DIV = 2;

  // ****************************************************************
  // Operand field positions
  // ****************************************************************
  localparam int PARAM_SRC_HI = 31;
  localparam int PARAM_SRC_LO = 18;
  localparam int CODE_SRC_HI = 17;
  localparam int CODE_SRC_LO = 4;
  localparam int START_NEW_BIT = 3;
  localparam int CLKSEL_W = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CORE_W-1:0] SLOT_RESET = 3'h0;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  localparam logic [NUM_CORES-1:0] LOCK_RESET = 8'h00;
  localparam logic [NUM_CORES-1:0] CHECKOUT_RESET = 8'h00;
  localparam logic [NUM_CORES-1:0] ACTIVE_RESET = 8'h00;

  // ****************************************************************
  // Access sizes and hub operations
  // ****************************************************************
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } size_e;

  typedef enum logic [3:0] {
    OP_MEM_READ_BYTE = 4'h0,
    OP_MEM_READ_WORD = 4'h1,
    OP_MEM_READ_LONG = 4'h2,
    OP_MEM_WRITE_BYTE = 4'h3,
    OP_MEM_WRITE_WORD = 4'h4,
    OP_MEM_WRITE_LONG = 4'h5,
    OP_CLOCK_SELECT_WRITE = 4'h6,
    OP_CORE_IDENTITY = 4'h7,
    OP_CORE_START = 4'h8,
    OP_CORE_STOP = 4'h9,
    OP_LOCK_CHECKOUT = 4'ha,
    OP_LOCK_RETURN = 4'hb,
    OP_LOCK_SET = 4'hc,
    OP_LOCK_CLEAR = 4'hd
  } op_e;

endpackage

// ==== hub_main_memory.sv ====
// Shared byte-addressed main memory with byte, word and long access.
// Assumes one access per cycle, issued by the hub for the slot owner.
`timescale 1ns/1ps
module hub_main_memory #(
  parameter int ADDR_W = hub_pkg::MEM_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire hub_pkg::size_e i_size,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  import hub_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem_q [2**ADDR_W];
  logic [ADDR_W-1:0] base;
  logic [3:0] lane_en;
  logic [7:0] rd_byte [4];
  logic [ADDR_W-1:0] lane_addr [4];

  // Alignment by size: word and long accesses ignore the low address bits
  always_comb begin
    base = i_addr;
    lane_en = 4'h1;
    case (i_size)
      SIZE_WORD: begin
        base = {i_addr[ADDR_W-1:1], 1'b0};
        lane_en = 4'h3;
      end
      SIZE_LONG: begin
        base = {i_addr[ADDR_W-1:2], 2'b00};
        lane_en = 4'hf;
      end
      default: begin
        base = i_addr;
        lane_en = 4'h1;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_addr[g] = base + ADDR_W'(g);
      assign rd_byte[g] = lane_en[g] ? mem_q[lane_addr[g]] : 8'h00;
    end
  endgenerate

  // One write process for all lanes keeps the array single-driven
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (i_we && lane_en[i]) begin
        mem_q[lane_addr[i]] <= i_wdata[8*i +: 8];
      end
    end
  end

  assign o_rdata = {rd_byte[3], rd_byte[2], rd_byte[1], rd_byte[0]};
endmodule

// ==== hub_slot_arbiter.sv ====
// Central hub: slot rotation, main memory access, clock select,
// core start/stop/identity and the lock inventory.
// Assumes each core holds its request, op and operands until o_done
// names it; core register loading is done by the started core itself
// from the boot record the hub hands out.
//
// Overview of operation
// - Hub ticks at half rate, one slot per core, each core every 16 clocks.
// - A requesting core stalls until its own slot comes round.
// - Fixed slot spacing gives 7 clocks after 9 free, 8 after two instructions.
// - Any core reaches the shared 64K-byte memory as bytes, words or longs.
// - Byte and word reads zero-extend; long reads return all bits.
// - Writes store low 8, low 16 or all 32 bits at the source address.
// - Word accesses align to even, long accesses to multiple-of-four addresses.
// - Clock-select operation writes low eight operand bits to global register.
// - Identity operation returns executing core number.
// - Start puts operand bits 31..18 into parameter bits 15..2.
// - Start operand bits 17..4 give long address of program to load.
// - Started core clears special registers then runs from address zero.
// - Bit 3 set starts lowest free core; carry flags none free.
// - Bit 3 clear starts or restarts the core named by bits 2..0.
// - Stop halts named core, held in reset until started again.
// - Eight lock inventory bits, all returned on reset.
// - Check-out grants a free lock number; carry set when none free.
// - Return frees the named lock in the inventory.
// - Set raises named lock bit, prior value into carry on request.
// - Clear lowers named lock bit, prior value into carry on request.
// - Only one core served per slot, so read and update never interleave.
// - Set and clear ignore check-out state.
`timescale 1ns/1ps
module hub_slot_arbiter #(
  parameter int NCORE = hub_pkg::NUM_CORES,
  parameter int ADDR_W = hub_pkg::MEM_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_req,
  input wire hub_pkg::op_e i_op [8],
  input wire logic [7:0][31:0] i_data,
  input wire logic [7:0][ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_carry_wr,
  output logic o_done,
  output logic [2:0] o_done_core,
  output logic [31:0] o_result,
  output logic o_carry,
  output logic o_carry_valid,
  output logic [7:0] o_clock_select,
  output logic [7:0] o_core_active,
  output logic o_boot_valid,
  output logic [2:0] o_boot_core,
  output logic [15:0] o_boot_param,
  output logic [15:0] o_boot_code_addr,
  output logic [7:0] o_lock_state,
  output logic [7:0] o_lock_checked_out,
  output logic [2:0] o_slot
);
  import hub_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic phase;
    logic [2:0] slot;
    logic [7:0] locks;
    logic [7:0] checked;
    logic [7:0] active;
    logic [7:0] clksel;
    logic done;
    logic [2:0] done_core;
    logic [31:0] result;
    logic carry;
    logic carry_valid;
    logic boot_valid;
    logic [2:0] boot_core;
    logic [15:0] boot_param;
    logic [15:0] boot_code;
  } hub_s;

  localparam hub_s HUB_RESET = '{
    phase: 1'b0,
    slot: SLOT_RESET,
    locks: LOCK_RESET,
    checked: CHECKOUT_RESET,
    active: ACTIVE_RESET,
    clksel: CLKSEL_RESET,
    done: 1'b0,
    done_core: 3'h0,
    result: 32'h0000_0000,
    carry: 1'b0,
    carry_valid: 1'b0,
    boot_valid: 1'b0,
    boot_core: 3'h0,
    boot_param: 16'h0000,
    boot_code: 16'h0000
  };

  hub_s s_q;
  hub_s s_d;

  // ****************************************************************
  // Memory port
  // ****************************************************************
  logic mem_we;
  size_e mem_size;
  logic [31:0] mem_rdata;

  hub_main_memory #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_size(mem_size),
    .i_addr(i_addr[s_q.slot]),
    .i_wdata(i_data[s_q.slot]),
    .o_rdata(mem_rdata)
  );

  // Lowest clear bit of a vector; found flag in bit 3
  function automatic logic [3:0] lowest_free(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic serve;
  op_e op;
  logic [31:0] d;
  logic [2:0] idx;
  logic [3:0] pick;
  logic [2:0] tgt;
  logic go;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.boot_valid = 1'b0;
    s_d.carry_valid = 1'b0;
    mem_we = 1'b0;
    mem_size = SIZE_BYTE;
    pick = 4'h0;
    tgt = 3'h0;
    go = 1'b0;
    op = i_op[s_q.slot];
    d = i_data[s_q.slot];
    idx = d[2:0];
    // Slot owner is served on the second clock of its hub tick
    serve = s_q.phase && i_req[s_q.slot];
    s_d.phase = ~s_q.phase;
    if (s_q.phase) begin
      s_d.slot = s_q.slot + 3'h1;
    end
    if (serve) begin
      s_d.done = 1'b1;
      s_d.done_core = s_q.slot;
      s_d.result = d;
      s_d.carry = 1'b0;
      case (op)
        OP_MEM_READ_BYTE: begin
          mem_size = SIZE_BYTE;
          s_d.result = mem_rdata;
        end
        OP_MEM_READ_WORD: begin
          mem_size = SIZE_WORD;
          s_d.result = mem_rdata;
        end
        OP_MEM_READ_LONG: begin
          mem_size = SIZE_LONG;
          s_d.result = mem_rdata;
        end
        OP_MEM_WRITE_BYTE: begin
          mem_size = SIZE_BYTE;
          mem_we = 1'b1;
        end
        OP_MEM_WRITE_WORD: begin
          mem_size = SIZE_WORD;
          mem_we = 1'b1;
        end
        OP_MEM_WRITE_LONG: begin
          mem_size = SIZE_LONG;
          mem_we = 1'b1;
        end
        OP_CLOCK_SELECT_WRITE: begin
          s_d.clksel = d[CLKSEL_W-1:0];
        end
        OP_CORE_IDENTITY: begin
          s_d.result = {29'h0, s_q.slot};
        end
        OP_CORE_START: begin
          if (d[START_NEW_BIT]) begin
            pick = lowest_free(s_q.active);
            go = pick[3];
            tgt = pick[2:0];
            s_d.carry = ~pick[3];
            s_d.carry_valid = i_carry_wr[s_q.slot];
            s_d.result = {29'h0, pick[2:0]};
          end else begin
            go = 1'b1;
            tgt = idx;
          end
          if (go) begin
            s_d.active[tgt] = 1'b1;
            s_d.boot_valid = 1'b1;
            s_d.boot_core = tgt;
            s_d.boot_param = {d[PARAM_SRC_HI:PARAM_SRC_LO], 2'b00};
            s_d.boot_code = {d[CODE_SRC_HI:CODE_SRC_LO], 2'b00};
          end
        end
        OP_CORE_STOP: begin
          s_d.active[idx] = 1'b0;
        end
        OP_LOCK_CHECKOUT: begin
          pick = lowest_free(s_q.checked);
          if (pick[3]) begin
            s_d.checked[pick[2:0]] = 1'b1;
          end
          s_d.carry = ~pick[3];
          s_d.carry_valid = i_carry_wr[s_q.slot];
          s_d.result = {29'h0, pick[2:0]};
        end
        OP_LOCK_RETURN: begin
          s_d.checked[idx] = 1'b0;
        end
        OP_LOCK_SET: begin
          s_d.carry = s_q.locks[idx];
          s_d.carry_valid = i_carry_wr[s_q.slot];
          s_d.locks[idx] = 1'b1;
        end
        OP_LOCK_CLEAR: begin
          s_d.carry = s_q.locks[idx];
          s_d.carry_valid = i_carry_wr[s_q.slot];
          s_d.locks[idx] = 1'b0;
        end
        default: begin
          s_d.result = d;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= HUB_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_done = s_q.done;
  assign o_done_core = s_q.done_core;
  assign o_result = s_q.result;
  assign o_carry = s_q.carry;
  assign o_carry_valid = s_q.carry_valid;
  assign o_clock_select = s_q.clksel;
  assign o_core_active = s_q.active;
  assign o_boot_valid = s_q.boot_valid;
  assign o_boot_core = s_q.boot_core;
  assign o_boot_param = s_q.boot_param;
  assign o_boot_code_addr = s_q.boot_code;
  assign o_lock_state = s_q.locks;
  assign o_lock_checked_out = s_q.checked;
  assign o_slot = s_q.slot;
endmodule

// ==== hub_slot_arbiter_properties.sv ====
// Concurrent checks on the hub slot arbiter ports.
// Assumes one clock domain; bound onto every hub_slot_arbiter instance.
`timescale 1ns/1ps
module hub_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_req,
  input wire hub_pkg::op_e i_op [8],
  input wire logic [7:0][31:0] i_data,
  input wire logic o_done,
  input wire logic [2:0] o_done_core,
  input wire logic [31:0] o_result,
  input wire logic o_carry,
  input wire logic [7:0] o_clock_select,
  input wire logic o_boot_valid,
  input wire logic [15:0] o_boot_param,
  input wire logic [15:0] o_boot_code_addr,
  input wire logic [7:0] o_lock_state,
  input wire logic [2:0] o_slot
);
  import hub_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] lock_prev_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_prev_q <= 8'h00;
    end else begin
      lock_prev_q <= o_lock_state;
    end
  end
  sequence s_srv(op_e op);
    o_done && i_op[o_done_core] == op;
  endsequence
  property p_slot_step;
    $changed(o_slot) |-> o_slot == 3'($past(o_slot) + 3'h1)
      ##1 $stable(o_slot) ##1 $changed(o_slot);
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot step");
  property p_slot_start;
    $rose(i_nrst) |-> o_slot == 3'h0 ##[1:3] $changed(o_slot);
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("slot start");
  property p_done_slot;
    o_done |-> i_req[o_done_core] && o_done_core == 3'(o_slot - 3'h1);
  endproperty
  a_done_slot: assert property (p_done_slot) else $error("done slot");
  property p_done_pulse;
    o_done |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done");
  property p_clk;
    s_srv(OP_CLOCK_SELECT_WRITE) |-> o_clock_select == i_data[o_done_core][7:0];
  endproperty
  a_clk: assert property (p_clk) else $error("clock select");
  property p_id;
    s_srv(OP_CORE_IDENTITY) |-> o_result == {29'h0, o_done_core};
  endproperty
  a_id: assert property (p_id) else $error("identity");
  property p_zext;
    s_srv(OP_MEM_READ_BYTE) |-> o_result[31:8] == 24'h0;
  endproperty
  a_zext: assert property (p_zext) else $error("byte read");
  property p_boot;
    o_boot_valid |-> o_done
      && o_boot_param == {i_data[o_done_core][31:18], 2'h0}
      && o_boot_code_addr == {i_data[o_done_core][17:4], 2'h0};
  endproperty
  a_boot: assert property (p_boot) else $error("boot record");
  property p_set;
    s_srv(OP_LOCK_SET) |-> o_lock_state[i_data[o_done_core][2:0]]
      && o_carry == lock_prev_q[i_data[o_done_core][2:0]];
  endproperty
  a_set: assert property (p_set) else $error("lock set");
  property p_clr;
    s_srv(OP_LOCK_CLEAR) |-> !o_lock_state[i_data[o_done_core][2:0]]
      && o_carry == lock_prev_q[i_data[o_done_core][2:0]];
  endproperty
  a_clr: assert property (p_clr) else $error("lock clear");
endmodule
bind hub_slot_arbiter hub_checker i_hub_checker (.*);

// ==== core_model.sv ====
// Eight cores: each raises its request and holds it until served.
// Assumes the bench holds op and operands while a request stands.
`timescale 1ns/1ps
module core_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_go,
  input wire logic i_done,
  input wire logic [2:0] i_done_core,
  output logic [7:0] o_req
);
  // ****************************************************************
  // Request hold
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_req <= 8'h00;
    end else begin
      o_req <= (o_req | i_go) & ~({7'h0, i_done} << i_done_core);
    end
  end
endmodule

// ==== hub_slot_arbiter_test.sv ====
// Self-checking bench for the hub slot arbiter.
// Assumes the core model holds each request until the hub answers it.
`timescale 1ns/1ps
module hub_slot_arbiter_test;
  import hub_pkg::*;
  logic clk, nrst, done, carry, bvalid, cy, cvalid, cv, bv;
  logic [2:0] dcore, bcore, slot;
  logic [7:0] go, req, cw, clksel, active, locks, chk_out;
  logic [15:0] bparam, baddr;
  logic [31:0] result, res;
  op_e op_a [8];
  logic [7:0][31:0] dat;
  logic [7:0][15:0] adr;
  int err_count, comparisons, n;
  hub_slot_arbiter i_hub_slot_arbiter (.i_clk(clk), .i_nrst(nrst),
    .i_req(req), .i_op(op_a), .i_data(dat), .i_addr(adr),
    .i_carry_wr(cw), .o_done(done), .o_done_core(dcore),
    .o_result(result), .o_carry(carry), .o_carry_valid(cvalid),
    .o_clock_select(clksel), .o_core_active(active),
    .o_boot_valid(bvalid), .o_boot_core(bcore), .o_boot_param(bparam),
    .o_boot_code_addr(baddr), .o_lock_state(locks),
    .o_lock_checked_out(chk_out), .o_slot(slot));
  core_model i_core_model (.i_clk(clk), .i_nrst(nrst), .i_go(go),
    .i_done(done), .i_done_core(dcore), .o_req(req));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hub_op(input logic [2:0] c, input op_e o,
                        input logic [31:0] d, input logic [15:0] a = 16'h0);
    op_a[c] = o;
    dat[c] = d;
    adr[c] = a;
    go[c] = 1'b1;
    @(posedge clk);
    #1 go[c] = 1'b0;
    n = 0;
    while (!(done === 1'b1 && dcore === c) && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("wait", 1, n <= 16);
    res = result;
    cy = carry;
    cv = cvalid;
    bv = bvalid;
    @(posedge clk);
    #1;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #300000;
    err_count++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    go = 8'h00;
    cw = 8'hff;
    dat = '0;
    adr = '0;
    for (int k = 0; k < 8; k++) op_a[k] = OP_CORE_IDENTITY;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    chk("slot", 0, slot);
    chk("inventory", 0, chk_out);
    chk("active", 0, active);
    for (int k = 0; k < 8; k++) begin
      hub_op(3'(k), OP_CORE_IDENTITY, 32'h0);
      chk("identity", k, res);
    end
    hub_op(3'h1, OP_CORE_IDENTITY, 32'h0);
    hub_op(3'h1, OP_CORE_IDENTITY, 32'h0);
    chk("resync", 14, n);
    hub_op(3'h2, OP_MEM_WRITE_LONG, 32'h89abcdef, 16'h0100);
    hub_op(3'h3, OP_MEM_READ_BYTE, 32'h0, 16'h0101);
    chk("rd byte", 32'hcd, res);
    hub_op(3'h4, OP_MEM_READ_WORD, 32'h0, 16'h0103);
    chk("rd word", 32'h89ab, res);
    hub_op(3'h5, OP_MEM_WRITE_BYTE, 32'hffffff55, 16'h0102);
    hub_op(3'h6, OP_MEM_WRITE_WORD, 32'hffff1234, 16'h0101);
    hub_op(3'h7, OP_MEM_READ_LONG, 32'h0, 16'h0103);
    chk("rd long", 32'h89551234, res);
    hub_op(3'h0, OP_MEM_WRITE_LONG, 32'h0badf00d, 16'hfffc);
    hub_op(3'h1, OP_MEM_READ_LONG, 32'h0, 16'hfffe);
    chk("top long", 32'h0badf00d, res);
    hub_op(3'h0, OP_CLOCK_SELECT_WRITE, 32'h123456a5);
    chk("clksel", 8'ha5, clksel);
    hub_op(3'h1, OP_LOCK_SET, 32'h5);
    chk("set prior", 0, cy);
    chk("carry valid", 1, cv);
    hub_op(3'h2, OP_LOCK_SET, 32'h5);
    chk("set prior", 1, cy);
    chk("lock bits", 8'h20, locks);
    hub_op(3'h3, OP_LOCK_CLEAR, 32'h5);
    chk("clr prior", 1, cy);
    cw = 8'hef;
    hub_op(3'h4, OP_LOCK_CLEAR, 32'h5);
    chk("clr prior", 0, cy);
    chk("carry valid", 0, cv);
    cw = 8'hff;
    for (int k = 0; k < 9; k++) begin
      hub_op(3'(k), OP_LOCK_CHECKOUT, 32'h0);
      chk("lock carry", k == 8, cy);
      if (k < 8) chk("lock num", k, res);
    end
    hub_op(3'h2, OP_LOCK_RETURN, 32'h3);
    chk("inventory", 8'hf7, chk_out);
    hub_op(3'h4, OP_LOCK_CHECKOUT, 32'h0);
    chk("reissue", 3, res);
    for (int k = 0; k < 9; k++) begin
      hub_op(3'(k), OP_CORE_START, 32'h8);
      chk("start carry", k == 8, cy);
      chk("boot issued", k < 8, bv);
      if (k < 8) chk("start num", k, res);
    end
    hub_op(3'h0, OP_CORE_STOP, 32'h2);
    chk("active", 8'hfb, active);
    hub_op(3'h1, OP_CORE_START, 32'haaa92348);
    chk("picked", 2, res);
    chk("param", 16'haaa8, bparam);
    chk("code", 16'h48d0, baddr);
    hub_op(3'h2, OP_CORE_START, 32'h6);
    chk("boot core", 6, bcore);
    chk("active", 8'hff, active);
    give_verdict();
  end
endmodule
